// ===== tcs_top.sv
/*
 Interrupt-enable and status registers for up to three timer channels behind AXI4-Lite.
 Gates match requests A to D with their enables, keeps the channel 0 D match flag, shows
 count direction and underflow. Assumes flag, count and direction inputs come from timer
 logic on aclk (no synchronisers) and event inputs are one-cycle pulses.
 // Functional notes
 // - channel 0 D request is high only while D enable and D flag are set
 // - channels 1 and 2: enable bit 3 reads zero, writes ignored
 // - channel 0 C request is high only while C enable and C flag are set
 // - channels 1 and 2: enable bit 2 reads zero, writes ignored
 // - every channel: B request needs enable bit 1 and B flag
 // - every channel: A request needs enable bit 0 and A flag
 // - one status register per channel; full build three, reduced build two
 // - channels 1 and 2 status bit 7 shows count direction, one is up
 // - channel 0 and reduced build: status bit 7 reads one, fixed
 // - status bit 6 always reads one in every channel
 // - channels 1 and 2 underflow flag sets on wrap 0000 to ffff in phase mode
 // - underflow clears by writing zero after reading one; writing one ignored
 // - channel 0 and reduced build: status bit 5 reads zero, fixed
 // - D flag sets on compare match or capture load into register D
*/
// Added by the designer: the register offsets and register access over AXI4-Lite.
`include "tcs_params.svh"
`default_nettype none
module tcs_top #(
	parameter int AXI_ADDR_W = 32,
	parameter bit FULL_VARIANT = 1'b1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// match flags from the compare/capture logic, A and B one bit per channel, C for channel 0 only
	input wire logic [2:0] match_a_flag,
	input wire logic [2:0] match_b_flag,
	input wire logic match_c_flag,
	// channel 0 register D events and external clear
	input wire logic d_compare_hit,
	input wire logic d_capture_load,
	input wire logic d_flag_clear,
	// counter state per channel
	input wire logic [2:0] count_up,
	input wire logic [2:0] phase_mode,
	input wire logic [15:0] timer_count [0:2],
	// interrupt requests and channel 0 D flag
	output logic [2:0] match_a_irq,
	output logic [2:0] match_b_irq,
	output logic match_c_irq,
	output logic match_d_irq,
	output logic match_d_flag
);
	// address must at least cover the three slots
	if (AXI_ADDR_W < `TCS_MAP_TOP + 1) begin : g_addr_check
		$error("AXI_ADDR_W too small for the register map");
	end

	tcs_chan_if ch_if [0:2] ();
	// write, read, flag and request state, grouped by path
	logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, w_lane0_r, w_lane0_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
	logic arready_r, arready_nxt, rvalid_r, rvalid_nxt, d_flag_r, d_flag_nxt;
	logic d_arm_r, d_arm_nxt, irq_c_r, irq_c_nxt, irq_d_r, irq_d_nxt, wr_go, rd_take, d_evt;
	logic [AXI_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	tcs_pkg::tcs_byte_type w_byte_r, w_byte_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	tcs_pkg::tcs_rd_state_type rd_state_r, rd_state_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [2:0] irq_a_r, irq_a_nxt, irq_b_r, irq_b_nxt, en_wr_vec, st_wr_vec, rd_st_vec, ch_uf;
	tcs_pkg::tcs_sel_type wr_sel, rd_sel;
	logic [3:0] ch_en [0:2];
	tcs_pkg::tcs_byte_type en_view [0:3], st_view [0:3];
	// a slot exists in this build; the reduced build lacks channel 0
	function automatic logic chan_live(input logic [1:0] ch);
		return (ch != `TCS_SLOT_NONE) && (FULL_VARIANT || ch != 2'h0);
	endfunction

	// byte address to slot, kind and hit; low two bits are ignored
	function automatic tcs_pkg::tcs_sel_type decode(input logic [AXI_ADDR_W-1:0] a);
		tcs_pkg::tcs_sel_type s;
		s.ch = a[`TCS_CH_MSB:`TCS_CH_LSB];
		s.status = a[`TCS_KIND_BIT];
		s.hit = chan_live(s.ch) && ((a >> `TCS_MAP_TOP) == '0);
		return s;
	endfunction

	assign wr_sel = decode(aw_addr_r);
	assign rd_sel = decode(s_axi_araddr);
	// a new write waits for the previous response, so one write is in flight at a time
	assign wr_go = aw_have_r && w_have_r && !bvalid_r;
	assign rd_take = s_axi_arvalid && arready_r;
	assign d_evt = FULL_VARIANT && (d_compare_hit || d_capture_load);

	// write path: address and data are caught independently, in either order
	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt = w_have_r;
		w_byte_nxt = w_byte_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && awready_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r) begin
			w_have_nxt = 1'b1;
			w_byte_nxt = s_axi_wdata[7:0];
			w_lane0_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_go) begin
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_sel.hit ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
		end
		awready_nxt = !aw_have_nxt;
		wready_nxt = !w_have_nxt;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
			w_have_r <= 1'b0;
			w_byte_r <= 8'h00;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `TCS_RESP_OKAY;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r <= w_have_nxt;
			w_byte_r <= w_byte_nxt;
			w_lane0_r <= w_lane0_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// per-channel strobes; a write without byte lane 0 is answered but changes nothing
	always_comb begin
		for (int i = 0; i < `TCS_NUM_SLOTS; i++) begin
			en_wr_vec[i] = wr_go && wr_sel.hit && !wr_sel.status && w_lane0_r &&
				(wr_sel.ch == 2'(i));
			st_wr_vec[i] = wr_go && wr_sel.hit && wr_sel.status && w_lane0_r &&
				(wr_sel.ch == 2'(i));
			rd_st_vec[i] = rd_take && rd_sel.hit && rd_sel.status && (rd_sel.ch == 2'(i));
		end
	end

	// read-back views; slot 3 stays zero, absent channel 0 is filled but never read
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			en_view[i] = 8'h00;
			st_view[i] = 8'h00;
		end
		for (int i = 0; i < `TCS_NUM_SLOTS; i++) begin
			en_view[i][3:0] = ch_en[i];
			en_view[i][`TCS_EN_RSV6] = 1'b1;
			st_view[i][`TCS_ST_DIR] = (FULL_VARIANT && i != 0) ? count_up[i] : 1'b1;
			st_view[i][`TCS_ST_RSV6] = 1'b1;
			st_view[i][`TCS_ST_UF] = ch_uf[i];
			st_view[i][`TCS_ST_A] = match_a_flag[i];
			st_view[i][`TCS_ST_B] = match_b_flag[i];
		end
		st_view[0][`TCS_ST_DIR] = 1'b1;
		st_view[0][`TCS_ST_C] = FULL_VARIANT && match_c_flag;
		st_view[0][`TCS_ST_D] = d_flag_r;
	end

	// read path: data are latched at the address handshake and held until rready
	always_comb begin
		rd_state_nxt = rd_state_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		unique case (rd_state_r)
			tcs_pkg::TCS_RD_IDLE: begin
				if (rd_take) begin
					rd_state_nxt = tcs_pkg::TCS_RD_RESP;
					rvalid_nxt = 1'b1;
					rresp_nxt = rd_sel.hit ? `TCS_RESP_OKAY : `TCS_RESP_SLVERR;
					rdata_nxt = 32'h0000_0000;
					if (rd_sel.hit) begin
						rdata_nxt[7:0] = rd_sel.status ? st_view[rd_sel.ch] : en_view[rd_sel.ch];
					end
				end
			end
			tcs_pkg::TCS_RD_RESP: begin
				if (s_axi_rready) begin
					rd_state_nxt = tcs_pkg::TCS_RD_IDLE;
					rvalid_nxt = 1'b0;
				end
			end
			default: begin
				rd_state_nxt = tcs_pkg::TCS_RD_IDLE;
				rvalid_nxt = 1'b0;
			end
		endcase
		arready_nxt = (rd_state_nxt == tcs_pkg::TCS_RD_IDLE);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= tcs_pkg::TCS_RD_IDLE;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= `TCS_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			rd_state_r <= rd_state_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// channel 0 D flag: sets on match or capture, clears by read-one-write-zero or externally
	always_comb begin
		d_flag_nxt = d_flag_r;
		d_arm_nxt = d_arm_r;
		if (rd_st_vec[0] && d_flag_r) begin
			d_arm_nxt = 1'b1;
		end
		if (d_flag_clear || (st_wr_vec[0] && !w_byte_r[`TCS_ST_D] && d_arm_r)) begin
			d_flag_nxt = 1'b0;
			d_arm_nxt = 1'b0;
		end
		if (d_evt) begin
			d_flag_nxt = 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d_flag_r <= `TCS_D_RST;
			d_arm_r <= 1'b0;
		end else begin
			d_flag_r <= d_flag_nxt;
			d_arm_r <= d_arm_nxt;
		end
	end

	// requests: registered AND of flag and enable, so they drop one cycle after either falls
	always_comb begin
		for (int i = 0; i < `TCS_NUM_SLOTS; i++) begin
			irq_a_nxt[i] = chan_live(2'(i)) && match_a_flag[i] && ch_en[i][`TCS_EN_A];
			irq_b_nxt[i] = chan_live(2'(i)) && match_b_flag[i] && ch_en[i][`TCS_EN_B];
		end
		irq_c_nxt = FULL_VARIANT && match_c_flag && ch_en[0][`TCS_EN_C];
		irq_d_nxt = FULL_VARIANT && d_flag_r && ch_en[0][`TCS_EN_D];
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_a_r <= 3'h0;
			irq_b_r <= 3'h0;
			irq_c_r <= 1'b0;
			irq_d_r <= 1'b0;
		end else begin
			irq_a_r <= irq_a_nxt;
			irq_b_r <= irq_b_nxt;
			irq_c_r <= irq_c_nxt;
			irq_d_r <= irq_d_nxt;
		end
	end

	// channel instances; only channels 1 and 2 of the full build count underflow
	for (genvar g = 0; g < `TCS_NUM_SLOTS; g++) begin : g_ch
		assign ch_if[g].en_wr = en_wr_vec[g];
		assign ch_if[g].st_wr = st_wr_vec[g];
		assign ch_if[g].rd_st = rd_st_vec[g];
		assign ch_if[g].wdata = w_byte_r;
		assign ch_en[g] = ch_if[g].en_q;
		assign ch_uf[g] = ch_if[g].uf_q;
		tcs_chan #(
			.HAS_CD(g == 0),
			.LIVE(FULL_VARIANT || g != 0),
			.UF_LIVE(FULL_VARIANT && g != 0)
		) u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.bus(ch_if[g]),
			.timer_count(timer_count[g]),
			.phase_mode(phase_mode[g])
		);
		AST_A_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
			(match_a_flag[g] && ch_en[g][`TCS_EN_A] && chan_live(2'(g))) |=> match_a_irq[g])
			else $error("A request missing while flag and enable set");
		AST_B_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
			!(match_b_flag[g] && ch_en[g][`TCS_EN_B]) |=> !match_b_irq[g])
			else $error("B request high without flag and enable");
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign match_a_irq = irq_a_r;
	assign match_b_irq = irq_b_r;
	assign match_c_irq = irq_c_r;
	assign match_d_irq = irq_d_r;
	assign match_d_flag = d_flag_r;
	// accepted read of a channel status word, on its address handshake
	sequence s_rd_status(int ch);
		rd_take && rd_sel.hit && rd_sel.status && rd_sel.ch == 2'(ch);
	endsequence
	AST_D_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		(d_flag_r && ch_en[0][`TCS_EN_D]) |=> match_d_irq)
		else $error("D request missing while flag and enable set");
	AST_D_DROP: assert property (@(posedge aclk) disable iff (!aresetn)
		($fell(ch_en[0][`TCS_EN_D]) || $fell(d_flag_r)) |=> !match_d_irq)
		else $error("D request did not drop after its cause fell");
	AST_C_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
		!(match_c_flag && ch_en[0][`TCS_EN_C]) |=> !match_c_irq)
		else $error("C request high without flag and enable");
	AST_D_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		d_evt |=> match_d_flag)
		else $error("D event did not set the D flag");
	AST_DIR_RD: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_rd_status(1) and FULL_VARIANT) |=> s_axi_rdata[`TCS_ST_DIR] == $past(count_up[1]))
		else $error("status bit 7 does not follow count direction");
	AST_RSV7_RD: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_rd_status(0) or (s_rd_status(2) and !FULL_VARIANT)) |=> s_axi_rdata[`TCS_ST_DIR])
		else $error("reserved status bit 7 read as zero");
	AST_RSV6_RD: assert property (@(posedge aclk) disable iff (!aresetn)
		(rd_take && rd_sel.hit && rd_sel.status) |=> s_axi_rvalid ##0 s_axi_rdata[`TCS_ST_RSV6])
		else $error("status bit 6 read as zero");
	AST_SLOT0_GONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(!FULL_VARIANT && rd_take && rd_sel.ch == 2'h0) |=> s_axi_rresp == `TCS_RESP_SLVERR)
		else $error("absent channel 0 answered as mapped");
	AST_WR_RESP: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write response not raised with address and data reopened");
endmodule
`default_nettype wire

// ===== tcs_params.svh
/*
 Register map, bit positions, reset values and response codes of the timer channel
 interrupt-enable and status block. Included by every design file that needs them.
*/
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH
// register slots: one enable and one status word per channel
`define TCS_NUM_SLOTS 3
`define TCS_CH_LSB 3
`define TCS_CH_MSB 4
`define TCS_KIND_BIT 2
`define TCS_MAP_TOP 5
`define TCS_SLOT_NONE 2'h3
// enable register fields
`define TCS_EN_A 0
`define TCS_EN_B 1
`define TCS_EN_C 2
`define TCS_EN_D 3
`define TCS_EN_RSV6 6
`define TCS_EN_RST 4'h0
// status register fields
`define TCS_ST_A 0
`define TCS_ST_B 1
`define TCS_ST_C 2
`define TCS_ST_D 3
`define TCS_ST_UF 5
`define TCS_ST_RSV6 6
`define TCS_ST_DIR 7
`define TCS_UF_RST 1'b0
`define TCS_D_RST 1'b0
// counter wrap points for underflow
`define TCS_CNT_ZERO 16'h0000
`define TCS_CNT_MAX 16'hffff
// bus responses
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
`endif

// ===== tcs_pkg.sv
/*
 Types shared by the timer channel status block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package tcs_pkg;
	typedef logic [7:0] tcs_byte_type;
	typedef struct packed {
		logic hit;
		logic [1:0] ch;
		logic status;
	} tcs_sel_type;
	typedef enum logic [1:0] {
		TCS_RD_IDLE = 2'b01,
		TCS_RD_RESP = 2'b10
	} tcs_rd_state_type;
endpackage
`default_nettype wire

// ===== tcs_chan_if.sv
/*
 Carrier between the bus front end and one channel's register logic.
 Assumes strobes are single-cycle pulses on the shared clock.
*/
`default_nettype none
interface tcs_chan_if;
	logic en_wr;
	logic st_wr;
	logic rd_st;
	tcs_pkg::tcs_byte_type wdata;
	logic [3:0] en_q;
	logic uf_q;
	modport ctl (output en_wr, output st_wr, output rd_st, output wdata, input en_q, input uf_q);
	modport chan (input en_wr, input st_wr, input rd_st, input wdata, output en_q, output uf_q);
endinterface
`default_nettype wire

// ===== tcs_chan.sv
/*
 One channel: enable bits A to D and the underflow flag with its read-then-write-zero clear.
 Assumes timer_count and phase_mode come from logic on aclk, so they are not synchronised.
*/
`include "tcs_params.svh"
`default_nettype none
module tcs_chan #(
	parameter bit HAS_CD = 1'b0,
	parameter bit LIVE = 1'b1,
	parameter bit UF_LIVE = 1'b0
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register strobes and read-back
	tcs_chan_if.chan bus,
	// counter observation
	input wire logic [15:0] timer_count,
	input wire logic phase_mode
);
	logic [3:0] en_r, en_nxt;
	logic [15:0] prev_r, prev_nxt;
	logic prev_ok_r, prev_ok_nxt;
	logic uf_r, uf_nxt;
	logic uf_arm_r, uf_arm_nxt;
	logic uf_evt;

	// wrap 0000 to ffff seen on consecutive cycles, only in phase counting
	assign uf_evt = UF_LIVE && phase_mode && prev_ok_r && (prev_r == `TCS_CNT_ZERO) &&
		(timer_count == `TCS_CNT_MAX);

	// next values; set beats clear so an underflow in the clearing cycle survives
	always_comb begin
		en_nxt = en_r;
		if (bus.en_wr && LIVE) begin
			en_nxt[`TCS_EN_A] = bus.wdata[`TCS_EN_A];
			en_nxt[`TCS_EN_B] = bus.wdata[`TCS_EN_B];
			en_nxt[`TCS_EN_C] = HAS_CD && bus.wdata[`TCS_EN_C];
			en_nxt[`TCS_EN_D] = HAS_CD && bus.wdata[`TCS_EN_D];
		end
		prev_nxt = timer_count;
		prev_ok_nxt = 1'b1;
		uf_nxt = uf_r;
		uf_arm_nxt = uf_arm_r;
		if (bus.rd_st && uf_r) begin
			uf_arm_nxt = 1'b1;
		end
		// writing a one is ignored; a zero only clears after a read of one
		if (bus.st_wr && !bus.wdata[`TCS_ST_UF] && uf_arm_r) begin
			uf_nxt = 1'b0;
			uf_arm_nxt = 1'b0;
		end
		if (uf_evt) begin
			uf_nxt = 1'b1;
		end
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_r <= `TCS_EN_RST;
			prev_r <= `TCS_CNT_ZERO;
			prev_ok_r <= 1'b0;
			uf_r <= `TCS_UF_RST;
			uf_arm_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			prev_r <= prev_nxt;
			prev_ok_r <= prev_ok_nxt;
			uf_r <= uf_nxt;
			uf_arm_r <= uf_arm_nxt;
		end
	end

	assign bus.en_q = en_r;
	assign bus.uf_q = uf_r && UF_LIVE;

	// read of one then write of zero
	sequence s_uf_clear_write;
		bus.st_wr && !bus.wdata[`TCS_ST_UF] && uf_arm_r && !uf_evt;
	endsequence

	AST_UF_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		uf_evt |=> uf_r)
		else $error("underflow did not set the flag");
	AST_UF_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		s_uf_clear_write |=> !uf_r)
		else $error("armed zero write did not clear underflow");
	AST_UF_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
		(bus.st_wr && bus.wdata[`TCS_ST_UF] && uf_r) |=> uf_r)
		else $error("writing one changed the underflow flag");
	AST_UF_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
		!UF_LIVE |-> !bus.uf_q)
		else $error("reserved underflow bit read as one");
	AST_EN_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
		(!HAS_CD && bus.en_wr) |=> (en_r[`TCS_EN_D:`TCS_EN_C] == 2'h0))
		else $error("reserved enable bits changed");
endmodule
`default_nettype wire

// ===== tcs_top_note_end.sv
`default_nettype none
`default_nettype wire

// ===== tcs_top_tb.sv
/*
 Self-checking bench for the timer channel interrupt-enable and status block.
 Drives a full and a reduced build side by side; assumes a 100 MHz aclk and the register map.
*/
`default_nettype none
module tcs_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [1:0] OK = 2'h0;
	localparam logic [1:0] ERR = 2'h2;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, araddr = 32'h0, wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] match_a_flag = 3'h0, match_b_flag = 3'h0, count_up = 3'h0, phase_mode = 3'h0;
	logic match_c_flag = 1'b0, d_compare_hit = 1'b0, d_capture_load = 1'b0, d_flag_clear = 1'b0;
	logic [15:0] tcount [0:2] = '{16'h1234, 16'h1234, 16'h1234};
	logic [2:0] a_irq, b_irq;
	logic c_irq, d_irq, d_flag;
	// reduced build outputs; its handshakes track the full build cycle for cycle
	logic [31:0] rdata2;
	logic [1:0] bresp2, rresp2;
	logic [2:0] a_irq2, b_irq2;
	logic c_irq2, d_irq2, d_flag2;
	// bench-side expectations and bookkeeping
	logic [33:0] rd_q [$];
	logic [1:0] wr_q [$];
	logic [33:0] rd2_q [$];
	logic [1:0] wr2_q [$];
	logic [2:0] uf_exp = 3'h0;
	logic d_exp = 1'b0;
	logic [15:0] lfsr_r = 16'h0001;
	logic [7:0] en_w [0:2];
	int n_mismatch = 0;
	int num_checks = 0;

	always #5 aclk = ~aclk;

	tcs_top #(.AXI_ADDR_W(32), .FULL_VARIANT(1'b1)) dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag),
		.match_c_flag(match_c_flag), .d_compare_hit(d_compare_hit),
		.d_capture_load(d_capture_load), .d_flag_clear(d_flag_clear), .count_up(count_up),
		.phase_mode(phase_mode), .timer_count(tcount), .match_a_irq(a_irq),
		.match_b_irq(b_irq), .match_c_irq(c_irq), .match_d_irq(d_irq), .match_d_flag(d_flag)
	);

	// reduced build on the same inputs: channel 0 absent
	tcs_top #(.AXI_ADDR_W(32), .FULL_VARIANT(1'b0)) dut_red (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(bresp2),
		.s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(),
		.s_axi_rdata(rdata2), .s_axi_rresp(rresp2), .s_axi_rvalid(),
		.s_axi_rready(rready), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag),
		.match_c_flag(match_c_flag), .d_compare_hit(d_compare_hit),
		.d_capture_load(d_capture_load), .d_flag_clear(d_flag_clear), .count_up(count_up),
		.phase_mode(phase_mode), .timer_count(tcount), .match_a_irq(a_irq2),
		.match_b_irq(b_irq2), .match_c_irq(c_irq2), .match_d_irq(d_irq2), .match_d_flag(d_flag2)
	);

	// 16-bit galois shift register, taps for a maximal sequence
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
	endfunction

	// expected enable read-back: bit 6 fixed one, only implemented enables survive
	function automatic logic [31:0] en_exp(input int ch, input logic [7:0] v);
		return {24'h0, 8'h40 | ((ch == 0) ? {4'h0, v[3:0]} : {6'h0, v[1:0]})};
	endfunction

	// expected status read-back from the levels the bench is driving
	function automatic logic [31:0] st_exp(input int ch);
		logic [7:0] r;
		r = {2'b11, 4'h0, match_b_flag[ch], match_a_flag[ch]};
		if (ch == 0) begin
			r[3:2] = {d_exp, match_c_flag};
		end else begin
			r[7] = count_up[ch];
			r[5] = uf_exp[ch];
		end
		return {24'h0, r};
	endfunction

	// reduced build: channel 0 unmapped, status bit 7 fixed one and bit 5 fixed zero
	function automatic logic [33:0] red_exp(input logic [31:0] a, input logic [33:0] e);
		if (a[4:3] == 2'h0 && a[31:5] == 27'h0) begin
			return {ERR, 32'h0};
		end
		if (a[2] && e[33:32] == OK) begin
			e[7] = 1'b1;
			e[5] = 1'b0;
		end
		return e;
	endfunction

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// write with address and data offered together; bready held until bvalid
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
			input logic [1:0] resp);
		logic aw_p;
		logic w_p;
		wr_q.push_back(resp);
		wr2_q.push_back((a[4:3] == 2'h0) ? ERR : resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (aw_p && awready) begin
				awvalid <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_p && wready) begin
				wvalid <= 1'b0;
				w_p = 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] resp);
		rd_q.push_back({resp, exp});
		rd2_q.push_back(red_exp(a, {resp, exp}));
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic irq_check();
		logic [2:0] a_e;
		logic [2:0] b_e;
		a_e = match_a_flag & {en_w[2][0], en_w[1][0], en_w[0][0]};
		b_e = match_b_flag & {en_w[2][1], en_w[1][1], en_w[0][1]};
		check({26'h0, a_irq, b_irq, c_irq, d_irq},
			{26'h0, a_e, b_e, match_c_flag & en_w[0][2], d_exp & en_w[0][3]});
		check({25'h0, a_irq2, b_irq2, c_irq2, d_irq2, d_flag2},
			{25'h0, a_e & 3'b110, b_e & 3'b110, 3'b000});
	endtask

	// response monitor: oldest note is compared whenever an answer is taken
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			check({rresp, rdata}, rd_q.pop_front());
			check({rresp2, rdata2}, rd2_q.pop_front());
		end
		if (bvalid === 1'b1 && bready === 1'b1) begin
			check({32'h0, bresp}, {32'h0, wr_q.pop_front()});
			check({32'h0, bresp2}, {32'h0, wr2_q.pop_front()});
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// hang guard, well above the few hundred cycles the sequence needs
	initial begin
		tick(20000);
		n_mismatch++;
		$display("wrong value at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		en_w = '{8'h0, 8'h0, 8'h0};
		tick(16);
		aresetn <= 1'b1;
		tick(1);
		// reset values, direction bit and the unmapped corners
		for (int pass = 0; pass < 2; pass++) begin
			for (int ch = 0; ch < 3; ch++) begin
				rd(8 * ch, en_exp(ch, 8'h0), OK);
				rd(8 * ch + 4, st_exp(ch), OK);
			end
			count_up <= 3'b111;
			tick(2);
		end
		rd(32'h18, 32'h0, ERR);
		rd(32'h24, 32'h0, ERR);
		wr(32'h1c, 8'hff, 4'h1, ERR);
		wr(32'h04, 8'hff, 4'h1, OK);
		rd(32'h04, st_exp(0), OK);
		// random enables and flags: gating, reserved enables, level drop
		for (int i = 0; i < 10; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			match_a_flag <= lfsr_r[10:8];
			match_b_flag <= lfsr_r[13:11];
			match_c_flag <= lfsr_r[14];
			count_up <= lfsr_r[15:13];
			en_w[0] = lfsr_r[7:0];
			en_w[1] = lfsr_r[15:8];
			en_w[2] = ~lfsr_r[7:0];
			for (int ch = 0; ch < 3; ch++) begin
				wr(8 * ch, en_w[ch], 4'h1, OK);
			end
			for (int ch = 1; ch < 3; ch++) begin
				en_w[ch][3:2] = 2'b00;
			end
			tick(2);
			irq_check();
			for (int ch = 0; ch < 3; ch++) begin
				rd(8 * ch, en_exp(ch, en_w[ch]), OK);
				rd(8 * ch + 4, st_exp(ch), OK);
			end
		end
		// a write with no byte strobe leaves the enables alone
		wr(32'h00, 8'h0, 4'h0, OK);
		rd(32'h00, en_exp(0, en_w[0]), OK);
		// underflow: phase mode on channel 1 only, both channels wrap 0000 to ffff
		phase_mode <= 3'b010;
		tcount[1] <= 16'h0000;
		tcount[2] <= 16'h0000;
		tick(1);
		tcount[1] <= 16'hffff;
		tcount[2] <= 16'hffff;
		tick(2);
		uf_exp[1] = 1'b1;
		wr(32'h0c, 8'h00, 4'h1, OK);
		rd(32'h0c, st_exp(1), OK);
		rd(32'h14, st_exp(2), OK);
		wr(32'h0c, 8'h20, 4'h1, OK);
		rd(32'h0c, st_exp(1), OK);
		wr(32'h0c, 8'h00, 4'h1, OK);
		uf_exp[1] = 1'b0;
		tcount[1] <= 16'h0000;
		tick(2);
		rd(32'h0c, st_exp(1), OK);
		// channel 0 D flag: compare hit, external clear, capture load, enable drop
		en_w[0] = 8'h08;
		wr(32'h00, en_w[0], 4'h1, OK);
		d_compare_hit <= 1'b1;
		tick(1);
		d_compare_hit <= 1'b0;
		tick(2);
		d_exp = 1'b1;
		check({33'h0, d_flag}, {33'h0, d_exp});
		irq_check();
		rd(32'h04, st_exp(0), OK);
		d_flag_clear <= 1'b1;
		tick(1);
		d_flag_clear <= 1'b0;
		tick(2);
		d_exp = 1'b0;
		irq_check();
		d_capture_load <= 1'b1;
		tick(1);
		d_capture_load <= 1'b0;
		tick(2);
		d_exp = 1'b1;
		irq_check();
		en_w[0] = 8'h00;
		wr(32'h00, en_w[0], 4'h1, OK);
		tick(1);
		irq_check();
		rd(32'h04, st_exp(0), OK);
		wr(32'h04, 8'h00, 4'h1, OK);
		d_exp = 1'b0;
		tick(1);
		check({33'h0, d_flag}, {33'h0, d_exp});
		tally_and_finish();
	end
endmodule
`default_nettype wire
